// ==== rtl/fd_mon_ctl.sv ====
// Fast-detect threshold flag and signal-monitor period and sync control
// Notes on behaviour
// - Flag pin driven only when enable set
// - Upper threshold low byte at 0x247
// - Upper threshold top five bits at 0x248
// - Lower threshold bytes at 0x249, 0x24A
// - Dwell count below lower before flag clears
// - Sync enable bit gates reference alignment
// - One-shot mode: first edge, then self-clear
// - Continuous mode resyncs on every edge
// - Force bit drives programmed pin value
// - Monitor period counter, 24-bit, even values; odd values are taken as written, not rounded
`timescale 1ns/1ps
module fd_mon_ctl
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire fd_mon_pkg::reg_req_t reg_req_i,
	input wire logic [12:0] magnitude_i,
	input wire logic sysref_i,
	output logic [7:0] reg_rdata_o,
	output logic threshold_flag_out_o,
	output logic monitor_sync_o,
	output logic monitor_period_end_o
);
	logic [7:0] fd_ctrl_reg;
	logic [12:0] upper_reg;
	logic [12:0] lower_reg;
	logic [15:0] dwell_reg;
	logic [1:0] sync_ctrl_reg;
	logic peak_en_reg;
	logic [23:0] period_reg;
	logic flag_reg;
	logic flag_next;
	logic [15:0] dwell_cnt_reg;
	logic [15:0] dwell_cnt_next;
	logic [23:0] mon_cnt_reg;
	logic [23:0] mon_cnt_next;
	logic sref_s1_reg;
	logic sref_s2_reg;
	logic sref_s3_reg;
	logic sref_lvl_reg;

	// Write decode
	wire wr_fd = reg_req_i.wr && reg_req_i.addr == fd_mon_pkg::ADDR_FD_CTRL;
	wire wr_up_lo = reg_req_i.wr && reg_req_i.addr == fd_mon_pkg::ADDR_UP_LO;
	wire wr_up_hi = reg_req_i.wr && reg_req_i.addr == fd_mon_pkg::ADDR_UP_HI;
	wire wr_lo_lo = reg_req_i.wr && reg_req_i.addr == fd_mon_pkg::ADDR_LO_LO;
	wire wr_lo_hi = reg_req_i.wr && reg_req_i.addr == fd_mon_pkg::ADDR_LO_HI;
	wire wr_dw_lo = reg_req_i.wr && reg_req_i.addr == fd_mon_pkg::ADDR_DWELL_LO;
	wire wr_dw_hi = reg_req_i.wr && reg_req_i.addr == fd_mon_pkg::ADDR_DWELL_HI;
	wire wr_sync = reg_req_i.wr && reg_req_i.addr == fd_mon_pkg::ADDR_SYNC_CTRL;
	wire wr_mon = reg_req_i.wr && reg_req_i.addr == fd_mon_pkg::ADDR_MON_CTRL;
	wire wr_p0 = reg_req_i.wr && reg_req_i.addr == fd_mon_pkg::ADDR_PERIOD0;
	wire wr_p1 = reg_req_i.wr && reg_req_i.addr == fd_mon_pkg::ADDR_PERIOD1;
	wire wr_p2 = reg_req_i.wr && reg_req_i.addr == fd_mon_pkg::ADDR_PERIOD2;
	wire [7:0] wd = reg_req_i.wdata;

	wire fd_en = fd_ctrl_reg[fd_mon_pkg::FD_EN_BIT];
	wire fd_force = fd_ctrl_reg[fd_mon_pkg::FD_FORCE_BIT];
	wire fd_fval = fd_ctrl_reg[fd_mon_pkg::FD_FVAL_BIT];
	wire sync_en = sync_ctrl_reg[fd_mon_pkg::SYNC_EN_BIT];
	wire sync_next = sync_ctrl_reg[fd_mon_pkg::SYNC_NEXT_BIT];

	// Read mux, reserved bits zero
	wire [7:0] rd_mux =
		reg_req_i.addr == fd_mon_pkg::ADDR_FD_CTRL ? fd_ctrl_reg :
		reg_req_i.addr == fd_mon_pkg::ADDR_UP_LO ? upper_reg[7:0] :
		reg_req_i.addr == fd_mon_pkg::ADDR_UP_HI ? {3'h0, upper_reg[12:8]} :
		reg_req_i.addr == fd_mon_pkg::ADDR_LO_LO ? lower_reg[7:0] :
		reg_req_i.addr == fd_mon_pkg::ADDR_LO_HI ? {3'h0, lower_reg[12:8]} :
		reg_req_i.addr == fd_mon_pkg::ADDR_DWELL_LO ? dwell_reg[7:0] :
		reg_req_i.addr == fd_mon_pkg::ADDR_DWELL_HI ? dwell_reg[15:8] :
		reg_req_i.addr == fd_mon_pkg::ADDR_SYNC_CTRL ? {6'h00, sync_ctrl_reg} :
		reg_req_i.addr == fd_mon_pkg::ADDR_MON_CTRL ? {6'h00, peak_en_reg, 1'h0} :
		reg_req_i.addr == fd_mon_pkg::ADDR_PERIOD0 ? period_reg[7:0] :
		reg_req_i.addr == fd_mon_pkg::ADDR_PERIOD1 ? period_reg[15:8] :
		reg_req_i.addr == fd_mon_pkg::ADDR_PERIOD2 ? period_reg[23:16] :
		fd_mon_pkg::RST_ZERO;

	// Comparator and dwell
	wire above_upper = magnitude_i > upper_reg;
	wire below_lower = magnitude_i < lower_reg;
	assign flag_next = above_upper ? 1'b1 :
		(below_lower && dwell_cnt_reg == 16'h0000) ? 1'b0 : flag_reg;
	assign dwell_cnt_next = !below_lower ? dwell_reg :
		dwell_cnt_reg == 16'h0000 ? dwell_cnt_reg : dwell_cnt_reg - 16'h0001;
	wire pin_next = fd_en && (fd_force ? fd_fval : flag_reg);

	// Reference edge: a change counts once stages two and three agree
	wire sref_agree = sref_s2_reg == sref_s3_reg;
	wire sref_edge = sref_agree && sref_s3_reg && !sref_lvl_reg;
	wire sync_fire = sync_en && sref_edge;
	// Even periods only; odd values are not rounded, the count still wraps after period_reg cycles
	wire period_wrap = mon_cnt_reg >= period_reg - 24'h000001;
	assign mon_cnt_next = (sync_fire || period_wrap) ? 24'h000000 :
		mon_cnt_reg + 24'h000001;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fd_ctrl_reg <= fd_mon_pkg::RST_ZERO;
			upper_reg <= 13'h0000;
			lower_reg <= 13'h0000;
			dwell_reg <= 16'h0000;
			peak_en_reg <= 1'b0;
			period_reg <= fd_mon_pkg::RST_PERIOD;
		end
		else
		begin
			if (wr_fd)
				fd_ctrl_reg <= {4'h0, wd[3:2], 1'b0, wd[0]};
			if (wr_up_lo)
				upper_reg[7:0] <= wd;
			if (wr_up_hi)
				upper_reg[12:8] <= wd[4:0];
			if (wr_lo_lo)
				lower_reg[7:0] <= wd;
			if (wr_lo_hi)
				lower_reg[12:8] <= wd[4:0];
			if (wr_dw_lo)
				dwell_reg[7:0] <= wd;
			if (wr_dw_hi)
				dwell_reg[15:8] <= wd;
			if (wr_mon)
				peak_en_reg <= wd[fd_mon_pkg::PEAK_EN_BIT];
			if (wr_p0)
				period_reg[7:0] <= wd;
			if (wr_p1)
				period_reg[15:8] <= wd;
			if (wr_p2)
				period_reg[23:16] <= wd;
		end
	end

	// Software write wins over the one-shot self-clear, so a re-arm is never lost
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sync_ctrl_reg <= 2'h0;
		else if (wr_sync)
			sync_ctrl_reg <= wd[1:0];
		else if (sync_fire && sync_next)
			sync_ctrl_reg[fd_mon_pkg::SYNC_EN_BIT] <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			flag_reg <= 1'b0;
			dwell_cnt_reg <= 16'h0000;
			mon_cnt_reg <= 24'h000000;
			sref_s1_reg <= 1'b0;
			sref_s2_reg <= 1'b0;
			sref_s3_reg <= 1'b0;
			sref_lvl_reg <= 1'b0;
			threshold_flag_out_o <= 1'b0;
			monitor_sync_o <= 1'b0;
			monitor_period_end_o <= 1'b0;
			reg_rdata_o <= fd_mon_pkg::RST_ZERO;
		end
		else
		begin
			flag_reg <= flag_next;
			dwell_cnt_reg <= dwell_cnt_next;
			mon_cnt_reg <= mon_cnt_next;
			sref_s1_reg <= sysref_i;
			sref_s2_reg <= sref_s1_reg;
			sref_s3_reg <= sref_s2_reg;
			if (sref_agree)
				sref_lvl_reg <= sref_s3_reg;
			threshold_flag_out_o <= pin_next;
			monitor_sync_o <= sync_fire;
			monitor_period_end_o <= period_wrap && !sync_fire;
			if (reg_req_i.rd)
				reg_rdata_o <= rd_mux;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_oneshot_capture;
		sync_fire && sync_next && !wr_sync;
	endsequence

	a_pin_disabled: assert property (!fd_en |=> !threshold_flag_out_o)
		else $error("flag pin high while fast detect disabled");
	a_upper_low_wr: assert property (wr_up_lo |=> upper_reg[7:0] == $past(wd))
		else $error("upper threshold low byte not stored");
	a_upper_high_wr: assert property (wr_up_hi |=> upper_reg[12:8] == $past(wd[4:0]))
		else $error("upper threshold high bits not stored");
	a_lower_thr_wr: assert property (wr_lo_hi |=> lower_reg[12:8] == $past(wd[4:0]))
		else $error("lower threshold high bits not stored");
	a_dwell_expire: assert property (flag_reg && !above_upper && below_lower
		&& dwell_cnt_reg == 16'h0000 |=> !flag_reg)
		else $error("flag not cleared after dwell");
	a_dwell_hold: assert property (flag_reg && below_lower
		&& dwell_cnt_reg != 16'h0000 |=> flag_reg)
		else $error("flag cleared before dwell expired");
	a_pin_follows: assert property (fd_en && !fd_force
		|=> threshold_flag_out_o == $past(flag_reg))
		else $error("flag pin does not follow internal flag");
	a_sync_gated: assert property (!sync_en |=> !monitor_sync_o)
		else $error("sync pulse while sync disabled");
	a_oneshot_clear: assert property (s_oneshot_capture |=> !sync_en ##1 !monitor_sync_o)
		else $error("one-shot sync did not self-clear");
	a_continuous: assert property (sync_fire && !sync_next && !wr_sync
		|=> sync_en && monitor_sync_o && mon_cnt_reg == 24'h000000)
		else $error("continuous sync lost or no realign");
	a_force_value: assert property (fd_en && fd_force
		|=> threshold_flag_out_o == $past(fd_fval))
		else $error("forced pin value wrong");
	a_period_wrap: assert property (period_wrap && !sync_fire
		|=> mon_cnt_reg == 24'h000000 && monitor_period_end_o)
		else $error("monitor period did not wrap");
	a_upper_sets: assert property (above_upper |=> flag_reg)
		else $error("flag not set above upper threshold");
	a_dwell_restart: assert property (!below_lower |=> dwell_cnt_reg == $past(dwell_reg))
		else $error("dwell count not restarted");
endmodule // fd_mon_ctl

// ==== rtl/fd_mon_pkg.sv ====
// Constants and carrier types for the fast-detect and monitor-sync block
package fd_mon_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int THR_W = 13;
	localparam int DWELL_W = 16;
	localparam int PERIOD_W = 24;
	localparam int THR_HI_W = 5;

	localparam logic [11:0] ADDR_FD_CTRL = 12'h245;
	localparam logic [11:0] ADDR_UP_LO = 12'h247;
	localparam logic [11:0] ADDR_UP_HI = 12'h248;
	localparam logic [11:0] ADDR_LO_LO = 12'h249;
	localparam logic [11:0] ADDR_LO_HI = 12'h24A;
	localparam logic [11:0] ADDR_DWELL_LO = 12'h24B;
	localparam logic [11:0] ADDR_DWELL_HI = 12'h24C;
	localparam logic [11:0] ADDR_SYNC_CTRL = 12'h26F;
	localparam logic [11:0] ADDR_MON_CTRL = 12'h270;
	localparam logic [11:0] ADDR_PERIOD0 = 12'h271;
	localparam logic [11:0] ADDR_PERIOD1 = 12'h272;
	localparam logic [11:0] ADDR_PERIOD2 = 12'h273;

	// Field positions
	localparam int FD_EN_BIT = 0;
	localparam int FD_FVAL_BIT = 2;
	localparam int FD_FORCE_BIT = 3;
	localparam int SYNC_EN_BIT = 0;
	localparam int SYNC_NEXT_BIT = 1;
	localparam int PEAK_EN_BIT = 1;

	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [23:0] RST_PERIOD = 24'h000080;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;
endpackage

// ==== sim/gain_ctl_model.sv ====
// Far-side gain-control model that watches the threshold flag pin
`timescale 1ns/1ps
module gain_ctl_model
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic flag_i,
	output int rise_count_o
);
	logic flag_reg;
	// Counts flag rises, the events the gain loop reacts to
	always_ff @(posedge clk_i)
	begin
		flag_reg <= flag_i;
		if (rst_i)
			rise_count_o <= 0;
		else if (flag_i && !flag_reg)
			rise_count_o <= rise_count_o + 1;
	end
endmodule // gain_ctl_model

// ==== sim/testbench.sv ====
// Self-checking bench for the fast-detect and monitor-sync block
`timescale 1ns/1ps
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	fd_mon_pkg::reg_req_t req = '0;
	logic [12:0] mag = 13'h0000;
	logic sysref = 1'b0;
	logic [7:0] rdata;
	logic flag, sync_p, pend;
	int rises;
	int bad_count = 0;
	int checks = 0;
	int syncs = 0;
	int ends = 0;
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		if (sync_p === 1'b1)
			syncs <= syncs + 1;
		if (pend === 1'b1)
			ends <= ends + 1;
	end
	fd_mon_ctl dut (.clk_i(clk_i), .rst_i(rst_i), .reg_req_i(req), .magnitude_i(mag),
		.sysref_i(sysref), .reg_rdata_o(rdata), .threshold_flag_out_o(flag),
		.monitor_sync_o(sync_p), .monitor_period_end_o(pend));
	gain_ctl_model partner (.clk_i(clk_i), .rst_i(rst_i), .flag_i(flag), .rise_count_o(rises));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Extra cycle keeps the strobe low for one edge between calls
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		tick(1);
		req.wr = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		req.rd = 1'b1;
		req.addr = a;
		tick(1);
		req.rd = 1'b0;
		tick(1);
		cmp(rdata, exp);
	endtask
	// Reference period 16 cycles, a multiple of the 8-cycle monitor period
	task automatic pulse_ref();
		sysref = 1'b1;
		tick(3);
		sysref = 1'b0;
		tick(13);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		end_of_test();
	end
	initial
	begin
		int e0;
		tick(2);
		rst_i = 1'b0;
		for (int a = 'h247; a <= 'h24C; a++) rd(12'(a), 8'h00);
		rd(12'h26F, 8'h00);
		rd(12'h270, 8'h00);
		wr(12'h248, 8'hFF);
		rd(12'h248, 8'h1F);
		wr(12'h24A, 8'hFF);
		rd(12'h24A, 8'h1F);
		$display("test registers done");
		wr(12'h247, 8'h64);
		wr(12'h248, 8'h01);
		wr(12'h249, 8'h32);
		wr(12'h24A, 8'h00);
		wr(12'h24B, 8'h02);
		mag = 13'h0190;
		tick(4);
		cmp({7'h00, flag}, 8'h00);
		mag = 13'h000A;
		tick(6);
		wr(12'h245, 8'h01);
		mag = 13'h012C;
		tick(4);
		cmp({7'h00, flag}, 8'h00);
		mag = 13'h0190;
		tick(3);
		cmp({7'h00, flag}, 8'h01);
		mag = 13'h000A;
		tick(2);
		mag = 13'h0040;
		tick(1);
		mag = 13'h000A;
		tick(3);
		cmp({7'h00, flag}, 8'h01);
		tick(1);
		cmp({7'h00, flag}, 8'h00);
		cmp(8'(rises), 8'h01);
		wr(12'h245, 8'h0D);
		tick(1);
		cmp({7'h00, flag}, 8'h01);
		wr(12'h245, 8'h09);
		tick(1);
		cmp({7'h00, flag}, 8'h00);
		$display("test flag done");
		wr(12'h271, 8'h08);
		pulse_ref();
		cmp(8'(syncs), 8'h00);
		wr(12'h26F, 8'h01); // Reference enabled before relying on it
		pulse_ref();
		pulse_ref();
		cmp(8'(syncs), 8'h02);
		wr(12'h26F, 8'h00);
		e0 = ends;
		tick(80);
		cmp(8'(ends - e0), 8'h0A);
		wr(12'h26F, 8'h03);
		e0 = syncs;
		pulse_ref();
		pulse_ref();
		cmp(8'(syncs - e0), 8'h01);
		rd(12'h26F, 8'h02);
		$display("test sync done");
		wr(12'h245, 8'hFF);
		rd(12'h245, 8'h0D);
		wr(12'h270, 8'hFF);
		rd(12'h270, 8'h02);
		// Mid-run reset must clear the fields written above and return the period low byte to 0x80
		rst_i = 1'b1;
		tick(2);
		rst_i = 1'b0;
		for (int a = 'h245; a <= 'h24C; a++) rd(12'(a), 8'h00);
		rd(12'h270, 8'h00);
		rd(12'h271, 8'h80);
		cmp({7'h00, flag}, 8'h00);
		$display("test reset done");
		end_of_test();
	end
endmodule // testbench
